/* logic/flash_rewrite_pkg.sv */
// constants, register map, field layouts and types of the flash self-rewrite controller
// assumes a single 10 MHz system clock and a same-clock cpu register port
package flash_rewrite_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_OP_STATUS      = 32'h4000_0400;
	localparam logic [31:0] ADDR_UNLOCK_KEY     = 32'h4000_0404;
	localparam logic [31:0] ADDR_TARGET_ADDRESS = 32'h4000_0408;
	localparam logic [31:0] ADDR_PROGRAM_WORD   = 32'h4000_040C;
	localparam logic [31:0] ADDR_ERASE_COMMAND  = 32'h4000_0410;
	localparam logic [31:0] ADDR_CAPACITY_BYTES = 32'h4000_0420;
	localparam logic [31:0] ADDR_BOOT_AREA      = 32'h4000_0424;
	localparam logic [31:0] ADDR_IRQ_STATUS     = 32'h4000_0430;
	localparam logic [31:0] ADDR_IRQ_ENABLE     = 32'h4000_0434;
	localparam logic [31:0] ADDR_IRQ_CLEAR      = 32'h4000_0438;

	// reset and fixed values
	localparam logic [31:0] TARGET_ADDR_RESET   = 32'h1000_0000;
	localparam logic [31:0] TARGET_ADDR_WR_MASK = 32'h0801_FFFC;
	localparam logic [31:0] CAPACITY_BYTES      = 32'h0001_0800;
	localparam logic [31:0] BOOT_AREA_START     = 32'h0000_F000;
	localparam logic [31:0] FLASH_BASE_ADDR     = 32'h1000_0000;

	// field positions
	localparam int BUSY_BIT      = 0;
	localparam int KEY_MSB       = 7;
	localparam int ERASE_MSB     = 1;
	localparam int IRQ_DONE_BIT  = 0;
	localparam int IRQ_ABORT_BIT = 1;
	localparam int IRQ_W         = 2;

	// unlock key values
	localparam logic [7:0] KEY_FIRST  = 8'hFA;
	localparam logic [7:0] KEY_SECOND = 8'hF5;

	// granule alignment masks: 1 KB sector, 8 KB block, 32-bit word
	localparam logic [31:0] SECTOR_ALIGN = 32'hFFFF_FC00;
	localparam logic [31:0] BLOCK_ALIGN  = 32'hFFFF_E000;
	localparam logic [31:0] WORD_ALIGN   = 32'hFFFF_FFFC;

	// erase command codes
	typedef enum logic [1:0] {
		ERASE_NONE   = 2'b00,
		ERASE_BAD    = 2'b01,
		ERASE_BLOCK  = 2'b10,
		ERASE_SECTOR = 2'b11
	} erase_kind_code_t;

	// array operation kinds
	typedef enum logic [1:0] {
		OP_IDLE    = 2'b00,
		OP_WORD    = 2'b01,
		OP_BLOCK   = 2'b10,
		OP_SECTOR  = 2'b11
	} op_kind_t;

	// unlock sequencer states
	typedef enum logic [1:0] {
		KEY_LOCKED = 2'b00,
		KEY_HALF   = 2'b01,
		KEY_ARMED  = 2'b10
	} key_state_t;

	// command held towards the flash array
	typedef struct packed {
		logic        hold;
		op_kind_t    kind;
		logic [31:0] addr;
		logic [31:0] data;
	} array_cmd_t;

	// operation times in microseconds and derived cycle counts at 10 MHz
	localparam int CLK_KHZ          = 10000;
	localparam int SECTOR_ERASE_US  = 20000;
	localparam int BLOCK_ERASE_US   = 40000;
	localparam int WORD_PROGRAM_US  = 40;
	localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * CLK_KHZ / 1000;
	localparam int BLOCK_ERASE_CYC  = BLOCK_ERASE_US * CLK_KHZ / 1000;
	localparam int WORD_PROGRAM_CYC = WORD_PROGRAM_US * CLK_KHZ / 1000;
	localparam int UNMAPPED_OP_CYC  = 2;

endpackage : flash_rewrite_pkg

/* logic/flash_self_rewrite_controller.sv */
// flash self-rewrite controller: unlock sequencer, operation timer, register port, interrupt
// assumes the cpu register port and flash read requests are on clk, registers answer one cycle later
module flash_self_rewrite_controller
	import flash_rewrite_pkg::*;
#(
	parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYC,
	parameter int unsigned BLOCK_CYCLES  = BLOCK_ERASE_CYC,
	parameter int unsigned WORD_CYCLES   = WORD_PROGRAM_CYC
) (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// register port
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_we,
	input  wire logic        reg_re,
	output logic      [31:0] reg_rdata,
	// cpu read path into the flash array
	input  wire logic        flash_rd_req,
	output logic             flash_rd_wait,
	// flash array command
	output array_cmd_t       array_cmd,
	// interrupt
	output logic             irq
);

	// register selects
	logic             wr_key;
	logic             wr_addr;
	logic             wr_word;
	logic             wr_erase;
	logic             wr_irq_en;
	logic             wr_irq_clr;

	// state
	key_state_t       key_q;
	key_state_t       key_d;
	logic [31:0]      target_q;
	erase_kind_code_t erase_q;
	logic             busy_q;
	logic [31:0]      cnt_q;
	array_cmd_t       cmd_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic [31:0]      rdata_q;

	// launch decisions
	logic             armed;
	logic             start_erase;
	logic             start_word;
	logic             launch;
	logic             unmapped;
	logic             seq_abort;
	logic [IRQ_W-1:0] irq_event;
	logic             op_done;
	op_kind_t         launch_kind;
	logic [31:0]      launch_addr;
	logic [31:0]      launch_cycles;
	logic [31:0]      flash_offset;

	// write decode
	assign wr_key     = reg_we && (reg_addr == ADDR_UNLOCK_KEY);
	assign wr_addr    = reg_we && (reg_addr == ADDR_TARGET_ADDRESS);
	assign wr_word    = reg_we && (reg_addr == ADDR_PROGRAM_WORD);
	assign wr_erase   = reg_we && (reg_addr == ADDR_ERASE_COMMAND);
	assign wr_irq_en  = reg_we && (reg_addr == ADDR_IRQ_ENABLE);
	assign wr_irq_clr = reg_we && (reg_addr == ADDR_IRQ_CLEAR);

	// launch conditions; writes while busy are dropped
	assign armed       = (key_q == KEY_ARMED);
	assign start_erase = wr_erase && !busy_q && armed &&
		((reg_wdata[ERASE_MSB:0] == ERASE_BLOCK) || (reg_wdata[ERASE_MSB:0] == ERASE_SECTOR));
	assign start_word  = wr_word && !busy_q && armed;
	assign launch      = start_erase || start_word;

	// operation kind and granule-aligned array address
	always_comb begin
		launch_kind = OP_WORD;
		launch_addr = target_q & WORD_ALIGN;
		if (start_erase && (reg_wdata[ERASE_MSB:0] == ERASE_SECTOR)) begin
			launch_kind = OP_SECTOR;
			launch_addr = target_q & SECTOR_ALIGN;
		end else if (start_erase) begin
			launch_kind = OP_BLOCK;
			launch_addr = target_q & BLOCK_ALIGN;
		end
	end

	// targets outside the implemented array finish almost at once
	assign flash_offset = target_q - FLASH_BASE_ADDR;
	assign unmapped     = (flash_offset >= CAPACITY_BYTES);

	// duration picked per kind
	always_comb begin
		launch_cycles = 32'(WORD_CYCLES);
		if (unmapped) begin
			launch_cycles = 32'(UNMAPPED_OP_CYC);
		end else if (launch_kind == OP_SECTOR) begin
			launch_cycles = 32'(SECTOR_CYCLES);
		end else if (launch_kind == OP_BLOCK) begin
			launch_cycles = 32'(BLOCK_CYCLES);
		end
	end

	// unlock sequencer next state; only key writes and, once armed, a launch change it
	always_comb begin
		key_d     = key_q;
		seq_abort = 1'b0;
		unique case (key_q)
			KEY_LOCKED: begin
				if (wr_key && (reg_wdata[KEY_MSB:0] == KEY_FIRST)) begin
					key_d = KEY_HALF;
				end
			end
			KEY_HALF: begin
				if (wr_key && (reg_wdata[KEY_MSB:0] == KEY_SECOND)) begin
					key_d = KEY_ARMED;
				end else if (wr_key) begin
					key_d     = KEY_LOCKED;
					seq_abort = 1'b1;
				end
			end
			KEY_ARMED: begin
				if (wr_key) begin
					key_d     = KEY_LOCKED;
					seq_abort = 1'b1;
				end else if (launch) begin
					key_d = KEY_LOCKED;
				end
			end
			default: begin
				key_d = KEY_LOCKED;
			end
		endcase
	end

	// unlock sequencer register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			key_q <= KEY_LOCKED;
		end else if (ce) begin
			key_q <= key_d;
		end
	end

	// target address: only the writable bits follow software
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			target_q <= TARGET_ADDR_RESET;
		end else if (ce && wr_addr && !busy_q) begin
			target_q <= (reg_wdata & TARGET_ADDR_WR_MASK) | (TARGET_ADDR_RESET & ~TARGET_ADDR_WR_MASK);
		end
	end

	// erase command field shows the running erase, clears on completion
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			erase_q <= ERASE_NONE;
		end else if (ce) begin
			if (start_erase) begin
				erase_q <= erase_kind_code_t'(reg_wdata[ERASE_MSB:0]);
			end else if (op_done) begin
				erase_q <= ERASE_NONE;
			end
		end
	end

	// operation timer: busy for exactly the loaded number of cycles
	assign op_done = busy_q && (cnt_q == 32'h0000_0001);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			cnt_q  <= 32'h0000_0000;
		end else if (ce) begin
			if (launch) begin
				busy_q <= 1'b1;
				cnt_q  <= launch_cycles;
			end else if (op_done) begin
				busy_q <= 1'b0;
				cnt_q  <= 32'h0000_0000;
			end else if (busy_q) begin
				cnt_q  <= cnt_q - 32'h0000_0001;
			end
		end
	end

	// array command held for the whole operation
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_q <= '0;
		end else if (ce) begin
			if (launch) begin
				cmd_q.hold <= !unmapped;
				cmd_q.kind <= unmapped ? OP_IDLE : launch_kind;
				cmd_q.addr <= launch_addr;
				cmd_q.data <= start_word ? reg_wdata : 32'h0000_0000;
			end else if (op_done) begin
				cmd_q <= '0;
			end
		end
	end

	assign array_cmd = cmd_q;

	// cpu reads of the array wait while an operation runs
	assign flash_rd_wait = flash_rd_req && busy_q;

	// interrupt enable register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irq_en_q <= '0;
		end else if (ce && wr_irq_en) begin
			irq_en_q <= reg_wdata[IRQ_W-1:0];
		end
	end

	// interrupt events: operation finished, key sequence aborted
	assign irq_event[IRQ_DONE_BIT]  = op_done;
	assign irq_event[IRQ_ABORT_BIT] = seq_abort;

	// sticky interrupt flags, one per event; a new event beats a clear in the same cycle
	for (genvar i = 0; i < IRQ_W; i++) begin : g_irq_flag
		always_ff @(posedge clk or negedge rstn) begin
			if (!rstn) begin
				irq_stat_q[i] <= 1'b0;
			end else if (ce) begin
				irq_stat_q[i] <= irq_event[i] || (irq_stat_q[i] && !(wr_irq_clr && reg_wdata[i]));
			end
		end
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// read data register: valid in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			rdata_q <= 32'h0000_0000;
			if (reg_re) begin
				unique case (reg_addr)
					ADDR_OP_STATUS: begin
						rdata_q[BUSY_BIT] <= busy_q;
					end
					ADDR_TARGET_ADDRESS: begin
						rdata_q <= target_q;
					end
					ADDR_ERASE_COMMAND: begin
						rdata_q[ERASE_MSB:0] <= erase_q;
					end
					ADDR_CAPACITY_BYTES: begin
						rdata_q <= CAPACITY_BYTES;
					end
					ADDR_BOOT_AREA: begin
						rdata_q <= BOOT_AREA_START;
					end
					ADDR_IRQ_STATUS: begin
						rdata_q[IRQ_W-1:0] <= irq_stat_q;
					end
					ADDR_IRQ_ENABLE: begin
						rdata_q[IRQ_W-1:0] <= irq_en_q;
					end
					default: begin
						rdata_q <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	assign reg_rdata = rdata_q;

endmodule : flash_self_rewrite_controller

/* bench/flash_ctrl_properties.sv */
// concurrent checks on the flash self-rewrite controller ports
// assumes one clock clk and the async active-low reset rstn
module flash_ctrl_properties
	import flash_rewrite_pkg::*;
#(
	parameter int unsigned SECTOR_CYCLES = SECTOR_ERASE_CYC,
	parameter int unsigned BLOCK_CYCLES  = BLOCK_ERASE_CYC,
	parameter int unsigned WORD_CYCLES   = WORD_PROGRAM_CYC
) (
	// clock, reset and enable
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ce,
	// register port
	input wire logic        reg_re,
	input wire logic [31:0] reg_rdata,
	// array side
	input wire logic        flash_rd_req,
	input wire logic        flash_rd_wait,
	input wire array_cmd_t  array_cmd
);
	timeunit 1ns;
	timeprecision 1ns;
	int unsigned hold_cnt_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// counts the cycles an operation holds the array
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			hold_cnt_q <= 0;
		else if (ce)
			hold_cnt_q <= array_cmd.hold ? hold_cnt_q + 1 : 0;
	end
	op_length_a: assert property ($fell(array_cmd.hold) |-> hold_cnt_q == ($past(array_cmd.kind) == OP_WORD ?
		WORD_CYCLES : $past(array_cmd.kind) == OP_BLOCK ? BLOCK_CYCLES : SECTOR_CYCLES)) else $error("bad op length");
	cmd_steady_a: assert property (array_cmd.hold && $past(array_cmd.hold) |-> $stable(array_cmd))
		else $error("array command moved");
	sector_align_a: assert property (array_cmd.hold && array_cmd.kind == OP_SECTOR |-> array_cmd.addr[9:0] == 10'h000)
		else $error("sector address not aligned");
	block_align_a: assert property (array_cmd.hold && array_cmd.kind == OP_BLOCK |-> array_cmd.addr[12:0] == 13'h0000)
		else $error("block address not aligned");
	word_align_a: assert property (array_cmd.hold && array_cmd.kind == OP_WORD |-> array_cmd.addr[1:0] == 2'h0)
		else $error("word address not aligned");
	erase_data_a: assert property (array_cmd.hold && array_cmd.kind != OP_WORD |-> array_cmd.data == 32'h0000_0000)
		else $error("erase carries data");
	read_wait_a: assert property (array_cmd.hold && flash_rd_req |-> flash_rd_wait)
		else $error("array read not stalled");
	wait_cause_a: assert property (flash_rd_wait |-> flash_rd_req) else $error("stall without read");
	rdata_idle_a: assert property ($past(ce) && !$past(reg_re) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read");
	// main operation kinds
	cover property ($rose(array_cmd.hold) && array_cmd.kind == OP_WORD);
	cover property ($rose(array_cmd.hold) && array_cmd.kind == OP_BLOCK);
	cover property ($rose(array_cmd.hold) && array_cmd.kind == OP_SECTOR);
endmodule : flash_ctrl_properties

bind flash_self_rewrite_controller flash_ctrl_properties #(.SECTOR_CYCLES(SECTOR_CYCLES),
	.BLOCK_CYCLES(BLOCK_CYCLES), .WORD_CYCLES(WORD_CYCLES)) flash_ctrl_properties_inst (.clk(clk), .rstn(rstn),
	.ce(ce), .reg_re(reg_re), .reg_rdata(reg_rdata), .flash_rd_req(flash_rd_req), .flash_rd_wait(flash_rd_wait),
	.array_cmd(array_cmd));

/* bench/flash_array_model.sv */
// behavioural flash array behind the controller's command port
// assumes array_cmd is registered on clk and held through each operation
module flash_array_model
	import flash_rewrite_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// command from the controller
	input  wire array_cmd_t array_cmd,
	// record of operations seen
	output array_cmd_t      last_cmd,
	output int              op_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hold_q;
	// takes each operation once, on its first held cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hold_q   <= 1'b0;
			last_cmd <= '0;
			op_count <= 0;
		end else begin
			hold_q <= array_cmd.hold;
			if (array_cmd.hold && !hold_q) begin
				last_cmd <= array_cmd;
				op_count <= op_count + 1;
			end
		end
	end
endmodule : flash_array_model

/* bench/flash_self_rewrite_controller_tb.sv */
// self-checking bench for the flash self-rewrite controller
// assumes short operation counts and a fresh, erased array model
module flash_self_rewrite_controller_tb;
	import flash_rewrite_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, reg_we = 1'b0, reg_re = 1'b0, flash_rd_req = 1'b0;
	logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, v;
	logic        flash_rd_wait, irq;
	array_cmd_t  array_cmd, last_cmd;
	int          op_count, base, errors = 0, comparisons = 0, cycles = 0;

	flash_self_rewrite_controller #(.SECTOR_CYCLES(20), .BLOCK_CYCLES(30), .WORD_CYCLES(5))
	flash_self_rewrite_controller_inst (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .flash_rd_req(flash_rd_req),
		.flash_rd_wait(flash_rd_wait), .array_cmd(array_cmd), .irq(irq));
	flash_array_model flash_array_model_inst (.clk(clk), .rstn(rstn), .array_cmd(array_cmd),
		.last_cmd(last_cmd), .op_count(op_count));

	// 10 MHz clock and a hang limit
	initial forever #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end

	task stop_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// one-cycle strobes, read data taken in the cycle after the strobe
	task wr(input logic [31:0] a, d);
		@(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_we <= 1'b1; end
		@(posedge clk) reg_we <= 1'b0;
	endtask : wr
	task rd(input logic [31:0] a);
		@(posedge clk) begin reg_addr <= a; reg_re <= 1'b1; end
		@(posedge clk) reg_re <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd
	task rdchk(input string name, input logic [31:0] a, exp);
		rd(a);
		check(name, v, exp);
	endtask : rdchk
	task arm;
		wr(ADDR_UNLOCK_KEY, 32'h0000_00FA);
		rdchk("boot", ADDR_BOOT_AREA, 32'h0000_F000);
		wr(ADDR_UNLOCK_KEY, 32'h0000_00F5);
	endtask : arm
	task none;
		rdchk("status", ADDR_OP_STATUS, 32'h0000_0000);
		check("count", 32'(op_count), 32'(base));
	endtask : none
	// armed launch, run, completion and the command seen by the array
	task op(input logic [31:0] ra, rv, input op_kind_t k, input logic [31:0] ea, ed, ec, input bit pre);
		base = op_count;
		arm();
		if (pre) begin
			wr(ADDR_ERASE_COMMAND, 32'h0000_0000);
			wr(ADDR_ERASE_COMMAND, 32'h0000_0001);
		end
		wr(ra, rv);
		flash_rd_req <= 1'b1;
		#1 check("wait", {31'h0, flash_rd_wait}, 32'h1);
		rdchk("busy", ADDR_OP_STATUS, 32'h0000_0001);
		@(posedge clk) flash_rd_req <= 1'b0;
		rdchk("erase run", ADDR_ERASE_COMMAND, ec);
		for (int i = 0; i < 60 && (i == 0 || v !== 32'h0); i++)
			rd(ADDR_OP_STATUS);
		rdchk("idle", ADDR_OP_STATUS, 32'h0000_0000);
		rdchk("erase end", ADDR_ERASE_COMMAND, 32'h0000_0000);
		check("count", 32'(op_count), 32'(base + 1));
		check("kind", {30'h0, last_cmd.kind}, {30'h0, k});
		check("addr", last_cmd.addr, ea);
		check("data", last_cmd.data, ed);
	endtask : op

	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rdchk("status", ADDR_OP_STATUS, 32'h0000_0000);
		rdchk("addr", ADDR_TARGET_ADDRESS, 32'h1000_0000);
		rdchk("key", ADDR_UNLOCK_KEY, 32'h0000_0000);
		rdchk("word", ADDR_PROGRAM_WORD, 32'h0000_0000);
		rdchk("size", ADDR_CAPACITY_BYTES, 32'h0001_0800);
		rdchk("unmapped", 32'h4000_0440, 32'h0000_0000);
		wr(ADDR_TARGET_ADDRESS, 32'hFFFF_FFFF);
		rdchk("addr mask", ADDR_TARGET_ADDRESS, 32'h1801_FFFC);
		wr(ADDR_TARGET_ADDRESS, 32'h1000_0104);
		wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
		// a low clock enable freezes the block, so this write is lost
		ce <= 1'b0;
		wr(ADDR_TARGET_ADDRESS, 32'h1000_0200);
		ce <= 1'b1;
		rdchk("addr frozen", ADDR_TARGET_ADDRESS, 32'h1000_0104);
		// launches without the keys are dropped
		base = op_count;
		wr(ADDR_PROGRAM_WORD, 32'h1234_5678);
		wr(ADDR_ERASE_COMMAND, 32'h0000_0003);
		none();
		// word program into the erased array, then the interrupt
		op(ADDR_PROGRAM_WORD, 32'hA5C3_0F96, OP_WORD, 32'h1000_0104, 32'hA5C3_0F96, 32'h0, 1'b0);
		check("irq", {31'h0, irq}, 32'h1);
		wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
		#1 check("irq masked", {31'h0, irq}, 32'h0);
		rdchk("irq status", ADDR_IRQ_STATUS, 32'h0000_0001);
		wr(ADDR_IRQ_ENABLE, 32'h0000_0001);
		wr(ADDR_IRQ_CLEAR, 32'h0000_0001);
		#1 check("irq clear", {31'h0, irq}, 32'h0);
		// arming is spent, broken and cancelled
		base = op_count;
		wr(ADDR_PROGRAM_WORD, 32'h0000_0000);
		none();
		wr(ADDR_UNLOCK_KEY, 32'h0000_00FA);
		wr(ADDR_UNLOCK_KEY, 32'h0000_0012);
		wr(ADDR_UNLOCK_KEY, 32'h0000_00F5);
		wr(ADDR_PROGRAM_WORD, 32'h0000_0000);
		none();
		arm();
		wr(ADDR_UNLOCK_KEY, 32'h0000_00F5);
		wr(ADDR_PROGRAM_WORD, 32'h0000_0000);
		none();
		// sector and block erase from an unaligned address
		wr(ADDR_TARGET_ADDRESS, 32'h1000_27FC);
		op(ADDR_ERASE_COMMAND, 32'h3, OP_SECTOR, 32'h1000_2400, 32'h0, 32'h3, 1'b1);
		op(ADDR_ERASE_COMMAND, 32'h2, OP_BLOCK, 32'h1000_2000, 32'h0, 32'h2, 1'b0);
		// target outside the array: short busy, array left alone
		wr(ADDR_TARGET_ADDRESS, 32'h0800_0000);
		base = op_count;
		arm();
		wr(ADDR_PROGRAM_WORD, 32'h0000_0000);
		flash_rd_req <= 1'b1;
		#1 check("short wait", {31'h0, flash_rd_wait}, 32'h1);
		@(posedge clk) flash_rd_req <= 1'b0;
		none();
		stop_test();
	end
endmodule : flash_self_rewrite_controller_tb
